// ==== hw/fwl_consts.vh ====
// Behaviour
// R1 - Latch low rejects all modifying commands
// R2 - Latch cleared after power-up and reset
// R3 - Disable and modifying commands clear latch
// R4 - Sequential end, abort, hold abort clear
// R5 - Incomplete opcode abort keeps latch set
// R6 - Premature abort clears after full opcode
// R7 - Busy flag follows internal operation
// R8 - Host polls status until busy drops
// R9 - Host sets latch before status write
// R10 - One data byte, extra bytes ignored
// R11 - Data bit 7 lock, 5:2 global code
// R12 - Select rise commits lock, clears latch
// R13 - Global action uses prior lock value
// R14 - Short data byte aborts, latch cleared
// R15 - Write-protect pin allows only lock set
// R16 - Identity bytes follow opcode, MSB first
// R17 - Maker, two device bytes, zero length
// R18 - Output floats after length byte
// R19 - Select rise ends identity read
// R20 - Busy at bit 0, latch bit 1
// R21 - Status write changes only bit 7
// R22 - MSB first, sample on rising clock
`ifndef FWL_CONSTS_VH
`define FWL_CONSTS_VH
`define FWL_OP_WREN 8'h06
`define FWL_OP_WRDI 8'h04
`define FWL_OP_RDSR 8'h05
`define FWL_OP_WRSR 8'h01
`define FWL_OP_RDID 8'h9F
`define FWL_OP_PROG 8'h02
`define FWL_OP_SPROG 8'hAD
`define FWL_OP_ER4K 8'h20
`define FWL_OP_ER32K 8'h52
`define FWL_OP_ER64K 8'hD8
`define FWL_OP_ERCHIP 8'h60
`define FWL_OP_ERCHIP2 8'hC7
`define FWL_OP_PROT 8'h36
`define FWL_OP_UNPROT 8'h39
`define FWL_SR_BUSY 0
`define FWL_SR_WEL 1
`define FWL_SR_SWP_LO 2
`define FWL_SR_SWP_HI 3
`define FWL_SR_WPP 4
`define FWL_SR_EPE 5
`define FWL_SR_SPM 6
`define FWL_SR_LOCK 7
`define FWL_WD_GLO_HI 5
`define FWL_WD_GLO_LO 2
`define FWL_GLOBAL_PROT 4'hF
`define FWL_GLOBAL_UNPROT 4'h0
`define FWL_ID_LEN 8'h00
`define FWL_ID_BYTES 3'h4
`define FWL_BIT_LAST 3'h7
`endif

// ==== hw/fwl_sync.v ====
`timescale 1ns/100ps
`default_nettype none
// Two-stage synchroniser for pin inputs
module fwl_sync (
	input wire clk_sys,
	input wire sys_rst,
	input wire din,
	input wire rst_val,
	output reg dout_ff
);
	reg meta_ff;

	// ----------------------------------------
	// Stages
	// ----------------------------------------
	// Reset value is a port only via clocked load; it is tied constant by the parent
	always @(posedge clk_sys) begin
		if (sys_rst) begin
			meta_ff <= rst_val;
			dout_ff <= rst_val;
		end else begin
			meta_ff <= din;
			dout_ff <= meta_ff;
		end
	end
endmodule
`default_nettype wire

// ==== hw/fwl_id_rom.v ====
`timescale 1ns/100ps
`default_nettype none
`include "fwl_consts.vh"
// Identity byte table with registered read data
module fwl_id_rom #(
	parameter [7:0] MFR_CODE = 8'hA5,  // arbitrary value
	parameter [7:0] DEV_CODE1 = 8'h5A, // arbitrary value
	parameter [7:0] DEV_CODE2 = 8'h3C  // arbitrary value
) (
	input wire clk_sys,
	input wire [1:0] addr,
	output reg [7:0] rdata_ff
);
	// ----------------------------------------
	// Lookup
	// ----------------------------------------
	// R17 byte order
	always @(posedge clk_sys) begin
		case (addr)
			2'h0: rdata_ff <= MFR_CODE;
			2'h1: rdata_ff <= DEV_CODE1;
			2'h2: rdata_ff <= DEV_CODE2;
			default: rdata_ff <= `FWL_ID_LEN;
		endcase
	end
endmodule
`default_nettype wire

// ==== hw/fwl_top.v ====
`timescale 1ns/100ps
`default_nettype none
`include "fwl_consts.vh"
// Serial flash command front end: write-enable latch, status, status write, identity
module fwl_top #(
	parameter [7:0] MFR_CODE = 8'hA5,  // arbitrary value
	parameter [7:0] DEV_CODE1 = 8'h5A, // arbitrary value
	parameter [7:0] DEV_CODE2 = 8'h3C  // arbitrary value
) (
	input wire clk_sys,
	input wire sys_rst,
	input wire spi_cs_n,
	input wire spi_sck,
	input wire spi_si,
	output reg spi_so_ff,
	output reg spi_so_oe_ff,
	input wire wp_n,
	input wire hold_n,
	input wire op_busy,
	input wire op_error,
	input wire seq_mode,
	input wire [1:0] swp_state,
	input wire seq_done,
	input wire op_abort,
	output reg op_start_ff,
	output reg [7:0] op_code_ff,
	output reg global_prot_ff,
	output reg global_unprot_ff,
	output reg protection_lock_bit_ff,
	output reg write_enable_latch_ff
);
	localparam ST_OPC = 2'h0;
	localparam ST_DATA = 2'h1;
	localparam ST_IGN = 2'h2;

	wire cs_n_s;
	wire sck_s;
	wire si_s;
	wire wp_n_s;
	wire hold_n_s;
	wire [7:0] id_byte;

	reg sck_d_ff;
	reg cs_d_ff;
	reg [1:0] st_ff;
	reg [1:0] nxt_st;
	reg [7:0] shift_ff;
	reg [2:0] bitcnt_ff;
	reg [7:0] opc_ff;
	reg full_opc_ff;
	reg wrsr_byte_ff;
	reg [7:0] wrsr_data_ff;
	reg id_mode_ff;
	reg sr_mode_ff;
	reg [2:0] id_idx_ff;
	reg [7:0] out_sh_ff;
	reg [7:0] status_byte;
	reg nxt_wel;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	// Select idles high, so its stages reset high and no false edge follows reset
	fwl_sync u_cs (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.din(spi_cs_n),
		.rst_val(1'b1),
		.dout_ff(cs_n_s)
	);
	// Serial clock idles low in mode 0
	fwl_sync u_sck (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.din(spi_sck),
		.rst_val(1'b0),
		.dout_ff(sck_s)
	);
	fwl_sync u_si (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.din(spi_si),
		.rst_val(1'b0),
		.dout_ff(si_s)
	);
	// Protect and hold pins reset to their released level
	fwl_sync u_wp (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.din(wp_n),
		.rst_val(1'b1),
		.dout_ff(wp_n_s)
	);
	fwl_sync u_hold (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.din(hold_n),
		.rst_val(1'b1),
		.dout_ff(hold_n_s)
	);

	fwl_id_rom #(.MFR_CODE(MFR_CODE), .DEV_CODE1(DEV_CODE1), .DEV_CODE2(DEV_CODE2)) u_rom (
		.clk_sys(clk_sys),
		.addr(id_idx_ff[1:0]),
		.rdata_ff(id_byte)
	);

	// Edge detect on synchronised levels; hold freezes the link
	wire active = ~cs_n_s & hold_n_s;
	wire sck_rise = active & sck_s & ~sck_d_ff;
	wire sck_fall = active & ~sck_s & sck_d_ff;
	wire cs_rise = cs_n_s & ~cs_d_ff;
	wire cs_fall = ~cs_n_s & cs_d_ff;
	wire [7:0] byte_in = {shift_ff[6:0], si_s};
	wire byte_done = sck_rise & (bitcnt_ff == `FWL_BIT_LAST);
	wire hold_abort = cs_rise & ~hold_n_s;

	// R1 modifying command set
	function is_mod;
		input [7:0] op;
		begin
			case (op)
				`FWL_OP_PROG, `FWL_OP_SPROG, `FWL_OP_ER4K, `FWL_OP_ER32K, `FWL_OP_ER64K,
				`FWL_OP_ERCHIP, `FWL_OP_ERCHIP2, `FWL_OP_PROT, `FWL_OP_UNPROT,
				`FWL_OP_WRSR: is_mod = 1'b1;
				default: is_mod = 1'b0;
			endcase
		end
	endfunction

	// ----------------------------------------
	// Status byte
	// ----------------------------------------
	// R7 busy passes straight through
	// R20 bit placement; only lock bit is ever written
	always @* begin
		status_byte = 8'h00;
		status_byte[`FWL_SR_BUSY] = op_busy;
		status_byte[`FWL_SR_WEL] = write_enable_latch_ff;
		status_byte[`FWL_SR_SWP_HI:`FWL_SR_SWP_LO] = swp_state;
		status_byte[`FWL_SR_WPP] = wp_n_s;
		status_byte[`FWL_SR_EPE] = op_error;
		status_byte[`FWL_SR_SPM] = seq_mode;
		status_byte[`FWL_SR_LOCK] = protection_lock_bit_ff;
	end

	// ----------------------------------------
	// Command framing
	// ----------------------------------------
	always @* begin
		nxt_st = st_ff;
		case (st_ff)
			ST_OPC: begin
				if (byte_done)
					nxt_st = (byte_in == `FWL_OP_WRSR) ? ST_DATA : ST_IGN;
			end
			ST_DATA: begin
				// R10 extra bytes ignored
				if (byte_done)
					nxt_st = ST_IGN;
			end
			ST_IGN: nxt_st = ST_IGN;
			default: nxt_st = ST_OPC;
		endcase
		if (cs_n_s)
			nxt_st = ST_OPC;
	end

	// R22 sample on rising edge, MSB first
	always @(posedge clk_sys) begin
		if (sys_rst) begin
			sck_d_ff <= 1'b0;
			cs_d_ff <= 1'b1;
			st_ff <= ST_OPC;
			shift_ff <= 8'h00;
			bitcnt_ff <= 3'h0;
			opc_ff <= 8'h00;
			full_opc_ff <= 1'b0;
			wrsr_byte_ff <= 1'b0;
			wrsr_data_ff <= 8'h00;
		end else begin
			sck_d_ff <= sck_s;
			cs_d_ff <= cs_n_s;
			st_ff <= nxt_st;
			if (cs_n_s | cs_fall) begin
				bitcnt_ff <= 3'h0;
				shift_ff <= 8'h00;
				if (cs_fall) begin
					full_opc_ff <= 1'b0;
					wrsr_byte_ff <= 1'b0;
				end
			end else if (sck_rise) begin
				shift_ff <= byte_in;
				bitcnt_ff <= bitcnt_ff + 3'h1;
				if (byte_done && st_ff == ST_OPC) begin
					opc_ff <= byte_in;
					full_opc_ff <= 1'b1;
				end
				if (byte_done && st_ff == ST_DATA) begin
					wrsr_data_ff <= byte_in;
					wrsr_byte_ff <= 1'b1;
				end
			end
		end
	end

	// ----------------------------------------
	// Write-enable latch, lock bit, global request
	// ----------------------------------------
	// Clear events first, so an enable landing in the same cycle wins
	always @* begin
		nxt_wel = write_enable_latch_ff;
		// R4 hold abort, sequential end or abort
		if (hold_abort || seq_done || op_abort)
			nxt_wel = 1'b0;
		// R5 incomplete opcode keeps latch, R6 full opcode clears
		if (cs_rise && full_opc_ff) begin
			// R3 disable and modifying commands clear
			if (opc_ff == `FWL_OP_WRDI || is_mod(opc_ff))
				nxt_wel = 1'b0;
			// Enable refused while an engine runs
			if (opc_ff == `FWL_OP_WREN && hold_n_s && !op_busy)
				nxt_wel = 1'b1;
		end
	end

	always @(posedge clk_sys) begin
		if (sys_rst) begin
			// R2 latch and lock cleared at reset
			write_enable_latch_ff <= 1'b0;
			protection_lock_bit_ff <= 1'b0;
			global_prot_ff <= 1'b0;
			global_unprot_ff <= 1'b0;
			op_start_ff <= 1'b0;
			op_code_ff <= 8'h00;
		end else begin
			write_enable_latch_ff <= nxt_wel;
			global_prot_ff <= 1'b0;
			global_unprot_ff <= 1'b0;
			op_start_ff <= 1'b0;
			// R1 gate on latch; engines start only when enabled
			if (cs_rise && hold_n_s && full_opc_ff && write_enable_latch_ff && !op_busy) begin
				// R14 short data byte: nothing but the latch clear
				if (opc_ff == `FWL_OP_WRSR && wrsr_byte_ff) begin
					// R15 write-protect blocks clearing the lock
					if (wp_n_s || wrsr_data_ff[`FWL_SR_LOCK]) begin
						// R12 R21 commit bit 7 only
						protection_lock_bit_ff <= wrsr_data_ff[`FWL_SR_LOCK];
						// R13 R11 global action uses prior lock
						if (!protection_lock_bit_ff) begin
							global_prot_ff <= (wrsr_data_ff[`FWL_WD_GLO_HI:`FWL_WD_GLO_LO]
								== `FWL_GLOBAL_PROT);
							global_unprot_ff <= (wrsr_data_ff[`FWL_WD_GLO_HI:`FWL_WD_GLO_LO]
								== `FWL_GLOBAL_UNPROT);
						end
					end
				end else if (is_mod(opc_ff) && opc_ff != `FWL_OP_WRSR) begin
					op_start_ff <= 1'b1;
					op_code_ff <= opc_ff;
				end
			end
		end
	end

	// ----------------------------------------
	// Serial output: identity and status reads
	// ----------------------------------------
	// Data changes on the falling edge so the host samples it on the next rise
	always @(posedge clk_sys) begin
		if (sys_rst) begin
			spi_so_ff <= 1'b0;
			spi_so_oe_ff <= 1'b0;
			id_mode_ff <= 1'b0;
			sr_mode_ff <= 1'b0;
			id_idx_ff <= 3'h0;
			out_sh_ff <= 8'h00;
		end else if (cs_n_s || !hold_n_s) begin
			// R19 select rise floats output
			spi_so_oe_ff <= 1'b0;
			if (cs_n_s) begin
				id_mode_ff <= 1'b0;
				sr_mode_ff <= 1'b0;
				id_idx_ff <= 3'h0;
			end
		end else begin
			if (byte_done && st_ff == ST_OPC) begin
				// R16 identity follows opcode
				id_mode_ff <= (byte_in == `FWL_OP_RDID);
				sr_mode_ff <= (byte_in == `FWL_OP_RDSR);
				out_sh_ff <= (byte_in == `FWL_OP_RDID) ? id_byte : status_byte;
				id_idx_ff <= 3'h1;
			end else if (byte_done && (id_mode_ff || sr_mode_ff)) begin
				// R8 fresh status each byte so busy can drop
				out_sh_ff <= id_mode_ff ? id_byte : status_byte;
				// Index stops one past the length byte, which marks the table's end
				id_idx_ff <= (id_idx_ff > `FWL_ID_BYTES) ? id_idx_ff : id_idx_ff + 3'h1;
			end else if (sck_rise) begin
				out_sh_ff <= {out_sh_ff[6:0], 1'b0};
			end
			// Next bit leaves on the fall, settled well before the host's rise
			if (sck_fall && (sr_mode_ff || id_mode_ff)) begin
				spi_so_ff <= out_sh_ff[7];
				// R18 float once the length byte is out
				spi_so_oe_ff <= ~(id_mode_ff && id_idx_ff > `FWL_ID_BYTES);
			end
		end
	end
endmodule
`default_nettype wire

// ==== sim/fwl_props.sv ====
`timescale 1ns/100ps
`default_nettype none
// Port-level checks on the latch, lock and pulse outputs
module fwl_props (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic spi_cs_n,
	input wire logic spi_so_oe_ff,
	input wire logic wp_n,
	input wire logic seq_done,
	input wire logic op_abort,
	input wire logic op_start_ff,
	input wire logic global_prot_ff,
	input wire logic global_unprot_ff,
	input wire logic protection_lock_bit_ff,
	input wire logic write_enable_latch_ff
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	// -----------------------------
	// Assertions
	// -----------------------------
	property p_rst_clear;
		disable iff (1'b0) sys_rst |=> !write_enable_latch_ff && !protection_lock_bit_ff;
	endproperty
	a_rst_clear: assert property (p_rst_clear) else $error("latch or lock set after reset");
	property p_start_wel;
		op_start_ff |-> $past(write_enable_latch_ff) && spi_cs_n;
	endproperty
	a_start_wel: assert property (p_start_wel) else $error("command accepted with latch low");
	property p_start_pulse;
		op_start_ff |=> !op_start_ff;
	endproperty
	a_start_pulse: assert property (p_start_pulse) else $error("start pulse too long");
	property p_global_prior;
		(global_prot_ff || global_unprot_ff) |->
			!$past(protection_lock_bit_ff) && $past(write_enable_latch_ff) && !write_enable_latch_ff;
	endproperty
	a_global_prior: assert property (p_global_prior) else $error("global action bad");
	property p_engine_clear;
		(seq_done || op_abort) |=> !write_enable_latch_ff;
	endproperty
	a_engine_clear: assert property (p_engine_clear) else $error("latch kept after engine end");
	property p_lock_wp;
		$fell(protection_lock_bit_ff) |-> wp_n;
	endproperty
	a_lock_wp: assert property (p_lock_wp) else $error("lock cleared while protected");
	property p_lock_commit;
		$changed(protection_lock_bit_ff) |-> spi_cs_n && $fell(write_enable_latch_ff);
	endproperty
	a_lock_commit: assert property (p_lock_commit) else $error("lock change not at commit");
	property p_oe_cs;
		spi_cs_n [*5] |-> !spi_so_oe_ff;
	endproperty
	a_oe_cs: assert property (p_oe_cs) else $error("output driven while deselected");
endmodule
`default_nettype wire

// ==== sim/fwl_host.sv ====
`timescale 1ns/100ps
`default_nettype none
// Host controller model, mode 0, 320 ns serial clock
module fwl_host (
	input wire logic spi_so,
	input wire logic spi_so_oe,
	output var logic spi_cs_n,
	output var logic spi_sck,
	output var logic spi_si
);
	initial begin
		spi_cs_n = 1'b1;
		spi_sck = 1'b0;
		spi_si = 1'b0;
	end
	// One frame: n bits from d, MSB first; q gathers the returned bits
	// shift order and edges
	task frame(input logic [31:0] d, input int n, output logic [31:0] q);
		q = '0;
		spi_cs_n = 1'b0;
		#160;
		for (int i = 0; i < n; i++) begin
			spi_si = d[31];
			d = d << 1;
			#160 spi_sck = 1'b1;
			// Pulled up when the device lets go
			q = {q[30:0], spi_so_oe ? spi_so : 1'b1};
			#160 spi_sck = 1'b0;
		end
		#160 spi_cs_n = 1'b1;
		// Released line must not keep the last bit
		spi_si = ~spi_si;
		#640;
	endtask
endmodule
`default_nettype wire

// ==== sim/fwl_top_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module fwl_top_tb;
	typedef struct {logic pre; logic [31:0] d; int n; logic wp, write_enable_latch, lock; int gp, gu;} fwl_row_t;
	logic clk_sys, sys_rst, wp_n, hold_n, op_busy, op_error, seq_mode, seq_done, op_abort;
	logic [1:0] swp_state;
	logic [31:0] q;
	wire spi_cs_n, spi_sck, spi_si, spi_so_ff, spi_so_oe_ff, op_start_ff;
	wire global_prot_ff, global_unprot_ff, protection_lock_bit_ff, write_enable_latch_ff;
	wire [7:0] op_code_ff;
	int n_fail, n_tests, n_gp, n_gu, n_st;
	// Latch before, frame, wp pin, then latch, lock and pulse totals
	fwl_row_t rows[12] = '{
		'{0, 32'h06000000, 8, 1, 1, 0, 0, 0},
		'{0, 32'h04000000, 8, 1, 0, 0, 0, 0},
		'{0, 32'h01800000, 16, 1, 0, 0, 0, 0},
		'{1, 32'h00000000, 4, 1, 1, 0, 0, 0},
		'{0, 32'h01000000, 8, 1, 0, 0, 0, 0},
		'{1, 32'h01800000, 12, 1, 0, 0, 0, 0},
		'{1, 32'h0180FF00, 24, 1, 0, 1, 0, 1},
		'{1, 32'h01000000, 16, 0, 0, 1, 0, 1},
		'{1, 32'h013C0000, 16, 1, 0, 0, 0, 1},
		'{1, 32'h01FF0000, 16, 1, 0, 1, 1, 1},
		'{1, 32'h01430000, 16, 1, 0, 0, 1, 1},
		'{1, 32'h01430000, 16, 1, 0, 0, 1, 2}};
	fwl_top fwl_top_i (.clk_sys, .sys_rst, .spi_cs_n, .spi_sck, .spi_si, .spi_so_ff,
		.spi_so_oe_ff, .wp_n, .hold_n, .op_busy, .op_error, .seq_mode, .swp_state,
		.seq_done, .op_abort, .op_start_ff, .op_code_ff, .global_prot_ff, .global_unprot_ff,
		.protection_lock_bit_ff, .write_enable_latch_ff);
	fwl_host fwl_host_i (.spi_so(spi_so_ff), .spi_so_oe(spi_so_oe_ff), .spi_cs_n, .spi_sck,
		.spi_si);
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	// Pulse totals, single-cycle outputs seen every edge
	always @(posedge clk_sys) begin
		n_gp += (global_prot_ff === 1'b1);
		n_gu += (global_unprot_ff === 1'b1);
		n_st += (op_start_ff === 1'b1);
	end
	task tick(input int n);
		repeat (n) @(posedge clk_sys);
		#2;
	endtask
	task send(input logic [31:0] d, input int n);
		fwl_host_i.frame(d, n, q);
		tick(8);
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		n_tests++;
		if (s !== e) begin
			n_fail++;
			$display("[ERR] %s exp %h got %h", nm, e, s);
		end
	endtask
	task results;
		$display("tests %0d fails %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Hang guard, well beyond the expected 0.2 ms
	initial begin
		#3ms;
		n_fail++;
		results;
	end
	// -----------------------------
	// Sequence
	// -----------------------------
	initial begin
		{sys_rst, wp_n, op_busy, op_error, seq_mode, swp_state, seq_done, op_abort} = 9'h180;
		hold_n = 1'b1;
		tick(6);
		sys_rst = 1'b0;
		tick(4);
		chk("wel_rst", 0, write_enable_latch_ff);
		foreach (rows[i]) begin
			wp_n = rows[i].wp;
			if (rows[i].pre) send(32'h06000000, 8);
			send(rows[i].d, rows[i].n);
			chk("wel", rows[i].write_enable_latch, write_enable_latch_ff);
			chk("lock", rows[i].lock, protection_lock_bit_ff);
			chk("gprot", rows[i].gp, n_gp);
			chk("gunprot", rows[i].gu, n_gu);
			$display("row %0d done", i);
		end
		{op_busy, op_error, seq_mode, swp_state} = 5'h1D;
		send(32'h06000000, 8);
		send(32'h05000000, 24);
		chk("status_busy", 16'h7575, q[15:0]);
		op_busy = 1'b0;
		send(32'h05000000, 16);
		chk("status_idle", 8'h74, q[7:0]);
		$display("status done");
		send(32'h06000000, 8);
		send(32'h02000000, 8);
		chk("start", 1, n_st);
		chk("opcode", 8'h02, op_code_ff);
		send(32'h06000000, 8);
		op_abort = 1'b1;
		tick(1);
		op_abort = 1'b0;
		tick(4);
		chk("wel_abort", 0, write_enable_latch_ff);
		send(32'h02000000, 8);
		chk("start_ref", 1, n_st);
		send(32'h06000000, 8);
		seq_done = 1'b1;
		tick(1);
		seq_done = 1'b0;
		tick(4);
		chk("wel_seq", 0, write_enable_latch_ff);
		send(32'h06000000, 8);
		hold_n = 1'b0;
		send(32'h05000000, 8);
		hold_n = 1'b1;
		chk("wel_hold", 0, write_enable_latch_ff);
		chk("so_hold", 8'hFF, q[7:0]);
		$display("engine done");
		send(32'h9F000000, 40);
		chk("ident", 24'hA55A3C, q[31:8]);
		chk("id_len", 8'h00, q[7:0]);
		send(32'h9F000000, 48);
		chk("float", 8'hFF, q[7:0]);
		send(32'h9F000000, 12);
		chk("id_part", 4'hA, q[3:0]);
		chk("oe_abort", 0, spi_so_oe_ff);
		$display("ident done");
		send(32'h06000000, 8);
		send(32'h01800000, 16);
		send(32'h06000000, 8);
		sys_rst = 1'b1;
		tick(6);
		sys_rst = 1'b0;
		tick(2);
		chk("rst_wel", 0, write_enable_latch_ff);
		chk("rst_lock", 0, protection_lock_bit_ff);
		$display("reset done");
		results;
	end
endmodule
bind fwl_top fwl_props fwl_props_i (.clk_sys, .sys_rst, .spi_cs_n, .spi_so_oe_ff, .wp_n,
	.seq_done, .op_abort, .op_start_ff, .global_prot_ff, .global_unprot_ff,
	.protection_lock_bit_ff, .write_enable_latch_ff);
`default_nettype wire
